/* File: include/bcsc_regs.vh */
// Constants of the battery charge stage controller: APB offsets, field
// positions, reset values and timing figures.
// Assumes a 40 MHz pclk and millivolt, degree and percent scaled inputs.
`ifndef BCSC_REGS_VH
`define BCSC_REGS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define BCSC_OFS_CTRL 8'h00
`define BCSC_OFS_VFULL 8'h04
`define BCSC_OFS_VLOW 8'h08
`define BCSC_OFS_VLIM 8'h0c
`define BCSC_OFS_TEMP 8'h10
`define BCSC_OFS_COUNT 8'h14
`define BCSC_OFS_DUR0 8'h18
`define BCSC_OFS_DUR1 8'h1c
`define BCSC_OFS_STAT 8'h20

// ****************************************************************
// Control register fields
// ****************************************************************
`define BCSC_CTRL_TYPE_LSB 0
`define BCSC_CTRL_INV_BIT 2
`define BCSC_CTRL_REST_BIT 3
`define BCSC_CTRL_PROT_LSB 4
`define BCSC_TYPE_ONOFF 2'h0
`define BCSC_TYPE_CAN 2'h1
`define BCSC_TYPE_ANALOG 2'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define BCSC_RST_CTRL 8'hf0
`define BCSC_RST_VFULL 16'h1000
`define BCSC_RST_EARLY 16'h0f00
`define BCSC_RST_DISB 16'h0014
`define BCSC_RST_PRECH 16'h0a00
`define BCSC_RST_RESTART 16'h0f80
`define BCSC_RST_OVOLT 16'h1100
`define BCSC_RST_MINTEMP 8'h01
`define BCSC_RST_HOT 8'h3c
`define BCSC_RST_FINCUR 16'h0010
`define BCSC_RST_NCELLS 16'h0010
`define BCSC_RST_DUR 16'h1c20
`define BCSC_RST_REST 16'h003c

// ****************************************************************
// Timing and thresholds
// ****************************************************************
`define BCSC_CLK_PERIOD_NS 25
`define BCSC_SEC_NS 1000000000
`define BCSC_TICK_CYC (`BCSC_SEC_NS / `BCSC_CLK_PERIOD_NS)
`define BCSC_EARLY_MV 16'h0005
`define BCSC_OVERSHOOT_MV 16'h0014
`define BCSC_DISSIP_S 16'h000a
`define BCSC_CAN_TIMEOUT_S 16'h000f
`define BCSC_RATE_DONE 7'h05

// ****************************************************************
// Stage codes
// ****************************************************************
`define BCSC_ST_IDLE 3'h0
`define BCSC_ST_PREHEAT 3'h1
`define BCSC_ST_PRECHG 3'h2
`define BCSC_ST_MAIN 3'h3
`define BCSC_ST_BAL 3'h4
`define BCSC_ST_FINISH 3'h5
`define BCSC_ST_ERROR 3'h6

`endif

/* File: core/bcsc_tick_div.v */
// One-second enable divider for the charge stage controller.
// Assumes a single free running clock.
`timescale 1ns/1ps
module bcsc_tick_div #(
  parameter CYC = 40000000
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Enable pulse
  output reg tick
);
  reg [31:0] cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_q >= CYC - 1) begin
      cnt_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // bcsc_tick_div

/* File: core/bcsc_sec_count.v */
// Saturating seconds counter, held at zero while clr is high.
// Assumes tick is a one-cycle enable from the divider.
`timescale 1ns/1ps
module bcsc_sec_count #(
  parameter W = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire clr,
  input wire tick,
  // Elapsed seconds
  output reg [W-1:0] secs
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secs <= {W{1'b0}};
    end else if (clr) begin
      secs <= {W{1'b0}};
    end else if (tick && (secs != {W{1'b1}})) begin
      secs <= secs + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // bcsc_sec_count

/* File: core/bcsc_stage_ctrl.v */
// Charging stage controller with APB configuration and status.
// Assumes measurement inputs are synchronous and already filtered.
//
// Notes on behaviour
// - Main charging early balancing: threshold is min cell plus 5mV, capped at max.
// - Max cell at fully charged voltage enters balancing; threshold defaults there.
// - Regulated charger: balancing ends on low current, full max, tight spread, rates.
// - On/off charger in balancing stays on until 20mV overshoot.
// - Overshoot turns charger off; threshold is min plus disbalance, capped full.
// - Charger-off phase lasts until max rate at most 5%, at least 10s.
// - Phase end: spread tight completes balancing, else charger on and repeat.
// - Balancing done enters charging finished with charger output off.
// - Error stage turns both charger and heater outputs off.
// - Cell comm loss is an error, except during restore window at start.
// - Overrun of pre, main or balancing maximum duration is an error.
// - Detected cell count unequal to configured count is an error.
// - Enabled and active current, insulation or sensor protection is an error.
// - Other critical checks ignore enables; under-voltage and charger-connected ignored.
// - Module or cell temperature above over-heat thresholds is an error.
// - Max cell above over-voltage threshold is an error.
// - Stages hold while entry condition holds; duration error needs reconnect.
// - Error may preempt any stage at any time; pre-heating may preempt any stage except error.
// - After balancing starts, no direct return to main charging.
// - After finished, no charging stage until max cell falls below restart.
// - Disconnection ends the process; reconnection starts it from scratch.
// - Configuration locked while charging except in error; mains invert allowed unless CAN type.
// - Coldest temperature below minimum enters pre-heating: heater on, charger off.
// - Min cell below precharge threshold enters pre-charging; skipped for on/off.
// - CAN charger counts disconnected after more than 15s without messages.
`timescale 1ns/1ps
`include "bcsc_regs.vh"
module bcsc_stage_ctrl #(
  parameter TICK_CYC = `BCSC_TICK_CYC
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Measurements
  input wire [15:0] max_cell_mv,
  input wire [15:0] min_cell_mv,
  input wire [7:0] lowest_temp,
  input wire [7:0] module_temp_max,
  input wire [7:0] cell_temp_max,
  input wire [15:0] cells_found,
  input wire cell_comm_ok,
  input wire [6:0] max_bal_rate,
  input wire [6:0] min_bal_rate,
  input wire [15:0] charge_current,
  input wire [3:0] prot_active,
  // Charger side
  input wire mains_present_input,
  input wire charger_msg_rx,
  output reg charger_on_output,
  output reg warmer_on_output,
  // Status
  output reg [2:0] stage_q,
  output reg [15:0] bal_thr_q,
  output reg bal_done_q
);
  localparam ST_IDLE = `BCSC_ST_IDLE;
  localparam ST_PREHEAT = `BCSC_ST_PREHEAT;
  localparam ST_PRECHG = `BCSC_ST_PRECHG;
  localparam ST_MAIN = `BCSC_ST_MAIN;
  localparam ST_BAL = `BCSC_ST_BAL;
  localparam ST_FINISH = `BCSC_ST_FINISH;
  localparam ST_ERROR = `BCSC_ST_ERROR;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  reg [7:0] ctrl_q;
  reg [15:0] vfull_q, early_q, disb_q, prech_q, restart_q, ovolt_q;
  reg [7:0] mintemp_q, modhot_q, cellhot_q;
  reg [15:0] fincur_q, ncells_q, dpre_q, dmain_q, dbal_q, drest_q;

  wire [1:0] ctype = ctrl_q[`BCSC_CTRL_TYPE_LSB+1:`BCSC_CTRL_TYPE_LSB];
  wire onoff = (ctype == `BCSC_TYPE_ONOFF);
  wire [3:0] prot_en = ctrl_q[`BCSC_CTRL_PROT_LSB+3:`BCSC_CTRL_PROT_LSB];

  // ****************************************************************
  // Timers
  // ****************************************************************
  wire tick;
  wire [15:0] stage_s, diss_s, can_s, rest_s;
  reg conn_q, can_alive_q, restore_q, fin_q, bal_q, dur_err_q, bal_off_q;
  reg [2:0] stage_d;
  reg bal_off_d, over_dur, hit;

  bcsc_tick_div #(.CYC(TICK_CYC)) u_tick (.pclk(pclk), .presetn(presetn),
    .tick(tick));
  bcsc_sec_count #(.W(16)) u_stage_t (.pclk(pclk), .presetn(presetn),
    .clr(stage_d != stage_q), .tick(tick), .secs(stage_s));
  bcsc_sec_count #(.W(16)) u_diss_t (.pclk(pclk), .presetn(presetn),
    .clr(!bal_off_q), .tick(tick), .secs(diss_s));
  bcsc_sec_count #(.W(16)) u_can_t (.pclk(pclk), .presetn(presetn),
    .clr(charger_msg_rx), .tick(tick), .secs(can_s));
  bcsc_sec_count #(.W(16)) u_rest_t (.pclk(pclk), .presetn(presetn),
    .clr(!restore_q), .tick(tick), .secs(rest_s));

  // ****************************************************************
  // Connection and conditions
  // ****************************************************************
  wire mains = mains_present_input ^ ctrl_q[`BCSC_CTRL_INV_BIT];
  wire conn_now = (ctype == `BCSC_TYPE_CAN) ? can_alive_q : mains;
  wire conn_start = conn_now & ~conn_q;
  wire [16:0] spread = {1'b0, max_cell_mv} - {1'b0, min_cell_mv};
  wire tight = spread < {1'b0, disb_q};
  wire cold = $signed(lowest_temp) < $signed(mintemp_q);
  wire below_restart = max_cell_mv < restart_q;
  wire fin_eff = fin_q & ~below_restart;
  wire rest_start = conn_start & ctrl_q[`BCSC_CTRL_REST_BIT] & ~cell_comm_ok;
  wire restore_now = restore_q | rest_start;
  wire comm_err = ~cell_comm_ok & ~restore_now;
  wire cnt_err = cell_comm_ok & (cells_found != ncells_q);
  wire prot_err = |(prot_en & prot_active);
  wire hot_err = cell_comm_ok &
    (($signed(module_temp_max) > $signed(modhot_q)) |
     ($signed(cell_temp_max) > $signed(cellhot_q)));
  wire ov_err = cell_comm_ok & (max_cell_mv > ovolt_q);
  always @* begin
    case (stage_q)
      ST_PRECHG: over_dur = stage_s > dpre_q;
      ST_MAIN: over_dur = stage_s > dmain_q;
      ST_BAL: over_dur = stage_s > dbal_q;
      default: over_dur = 1'b0;
    endcase
  end
  wire err_now = comm_err | cnt_err | prot_err | hot_err | ov_err |
    dur_err_q | over_dur;

  // ****************************************************************
  // Balancing completion
  // ****************************************************************
  wire [16:0] over_lim = {1'b0, vfull_q} + {1'b0, `BCSC_OVERSHOOT_MV};
  wire overshoot = {1'b0, max_cell_mv} > over_lim;
  wire diss_end = (max_bal_rate <= `BCSC_RATE_DONE) &&
    (diss_s >= `BCSC_DISSIP_S);
  wire reg_done = (charge_current < fincur_q) &&
    (max_cell_mv == vfull_q) && tight &&
    ({1'b0, min_bal_rate} > {2'b0, max_bal_rate[6:1]});
  wire done_now = (stage_q == ST_BAL) & conn_now & ~err_now & ~cold &
    (onoff ? (bal_off_q & diss_end & tight) : reg_done);

  // ****************************************************************
  // Stage selection
  // ****************************************************************
  wire bal_hold = (bal_q | (stage_q == ST_BAL)) & ~(fin_q & below_restart);
  always @* begin
    stage_d = stage_q;
    if (!conn_now) begin
      stage_d = ST_IDLE;
    end else if (err_now) begin
      stage_d = ST_ERROR;
    end else if (cold) begin
      stage_d = ST_PREHEAT;
    end else if (restore_now) begin
      stage_d = onoff ? ST_MAIN : ST_PRECHG;
    end else if (fin_eff | done_now) begin
      stage_d = ST_FINISH;
    end else if (bal_hold | (max_cell_mv >= vfull_q)) begin
      stage_d = ST_BAL;
    end else if ((min_cell_mv < prech_q) & ~onoff) begin
      stage_d = ST_PRECHG;
    end else begin
      stage_d = ST_MAIN;
    end
  end

  always @* begin
    bal_off_d = 1'b0;
    if ((stage_d == ST_BAL) && onoff) begin
      if (!bal_off_q) begin
        bal_off_d = overshoot;
      end else begin
        bal_off_d = ~diss_end;
      end
    end
  end

  // ****************************************************************
  // Threshold and outputs
  // ****************************************************************
  wire [16:0] early_sum = {1'b0, min_cell_mv} + {1'b0, `BCSC_EARLY_MV};
  wire [16:0] diss_sum = {1'b0, min_cell_mv} + {1'b0, disb_q};
  wire early_on = (max_cell_mv > early_q) && (spread > {1'b0, disb_q});
  reg [15:0] thr_d;
  always @* begin
    thr_d = vfull_q;
    if ((stage_d == ST_MAIN) && early_on) begin
      if (early_sum > {1'b0, max_cell_mv}) begin
        thr_d = max_cell_mv;
      end else begin
        thr_d = early_sum[15:0];
      end
    end else if (bal_off_d) begin
      if (diss_sum > {1'b0, vfull_q}) begin
        thr_d = vfull_q;
      end else begin
        thr_d = diss_sum[15:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_q <= ST_IDLE;
      conn_q <= 1'b0;
      can_alive_q <= 1'b0;
      restore_q <= 1'b0;
      fin_q <= 1'b0;
      bal_q <= 1'b0;
      dur_err_q <= 1'b0;
      bal_off_q <= 1'b0;
      bal_thr_q <= `BCSC_RST_VFULL;
      bal_done_q <= 1'b0;
      charger_on_output <= 1'b0;
      warmer_on_output <= 1'b0;
    end else begin
      stage_q <= stage_d;
      conn_q <= conn_now;
      bal_off_q <= bal_off_d;
      bal_thr_q <= thr_d;
      bal_done_q <= done_now;
      if (charger_msg_rx) begin
        can_alive_q <= 1'b1;
      end else if (can_s > `BCSC_CAN_TIMEOUT_S) begin
        can_alive_q <= 1'b0;
      end
      if (!conn_now) begin
        restore_q <= 1'b0;
        fin_q <= 1'b0;
        bal_q <= 1'b0;
        dur_err_q <= 1'b0;
      end else if (conn_start) begin
        restore_q <= ctrl_q[`BCSC_CTRL_REST_BIT] & ~cell_comm_ok;
        fin_q <= 1'b0;
        bal_q <= 1'b0;
        dur_err_q <= 1'b0;
      end else begin
        if (cell_comm_ok || (rest_s >= drest_q)) begin
          restore_q <= 1'b0;
        end
        if (done_now) begin
          fin_q <= 1'b1;
        end else if (below_restart) begin
          fin_q <= 1'b0;
        end
        if (stage_q == ST_BAL) begin
          bal_q <= 1'b1;
        end else if (fin_q & below_restart) begin
          bal_q <= 1'b0;
        end
        if (over_dur) begin
          dur_err_q <= 1'b1;
        end
      end
      charger_on_output <= (stage_d == ST_PRECHG) |
        (stage_d == ST_MAIN) |
        ((stage_d == ST_BAL) & ~bal_off_d);
      warmer_on_output <= (stage_d == ST_PREHEAT);
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // No wait states: the answer is prepared in the setup cycle.
  wire locked = conn_q & (stage_q != ST_ERROR);
  wire inv_only = locked & (paddr == `BCSC_OFS_CTRL) &
    (ctype != `BCSC_TYPE_CAN);
  reg [31:0] rd_d;
  always @* begin
    hit = 1'b1;
    rd_d = 32'h0;
    case (paddr)
      `BCSC_OFS_CTRL: rd_d = {24'h0, ctrl_q};
      `BCSC_OFS_VFULL: rd_d = {early_q, vfull_q};
      `BCSC_OFS_VLOW: rd_d = {prech_q, disb_q};
      `BCSC_OFS_VLIM: rd_d = {ovolt_q, restart_q};
      `BCSC_OFS_TEMP: rd_d = {8'h0, cellhot_q, modhot_q, mintemp_q};
      `BCSC_OFS_COUNT: rd_d = {ncells_q, fincur_q};
      `BCSC_OFS_DUR0: rd_d = {dmain_q, dpre_q};
      `BCSC_OFS_DUR1: rd_d = {drest_q, dbal_q};
      `BCSC_OFS_STAT: rd_d = {bal_thr_q, 8'h0, dur_err_q, restore_q,
        conn_q, warmer_on_output, charger_on_output, stage_q};
      default: hit = 1'b0;
    endcase
  end
  wire ro_hit = (paddr == `BCSC_OFS_STAT);
  wire bad = ~hit | (pwrite & (ro_hit | (locked & ~inv_only)));
  wire wr_go = psel & penable & pready & pwrite & ~pslverr;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & bad;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0 : rd_d;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `BCSC_RST_CTRL;
      vfull_q <= `BCSC_RST_VFULL;
      early_q <= `BCSC_RST_EARLY;
      disb_q <= `BCSC_RST_DISB;
      prech_q <= `BCSC_RST_PRECH;
      restart_q <= `BCSC_RST_RESTART;
      ovolt_q <= `BCSC_RST_OVOLT;
      mintemp_q <= `BCSC_RST_MINTEMP;
      modhot_q <= `BCSC_RST_HOT;
      cellhot_q <= `BCSC_RST_HOT;
      fincur_q <= `BCSC_RST_FINCUR;
      ncells_q <= `BCSC_RST_NCELLS;
      dpre_q <= `BCSC_RST_DUR;
      dmain_q <= `BCSC_RST_DUR;
      dbal_q <= `BCSC_RST_DUR;
      drest_q <= `BCSC_RST_REST;
    end else if (wr_go) begin
      case (paddr)
        `BCSC_OFS_CTRL: begin
          if (locked) begin
            ctrl_q[`BCSC_CTRL_INV_BIT] <= pwdata[`BCSC_CTRL_INV_BIT];
          end else begin
            ctrl_q <= pwdata[7:0];
          end
        end
        `BCSC_OFS_VFULL: {early_q, vfull_q} <= pwdata;
        `BCSC_OFS_VLOW: {prech_q, disb_q} <= pwdata;
        `BCSC_OFS_VLIM: {ovolt_q, restart_q} <= pwdata;
        `BCSC_OFS_TEMP: {cellhot_q, modhot_q, mintemp_q} <= pwdata[23:0];
        `BCSC_OFS_COUNT: {ncells_q, fincur_q} <= pwdata;
        `BCSC_OFS_DUR0: {dmain_q, dpre_q} <= pwdata;
        `BCSC_OFS_DUR1: {drest_q, dbal_q} <= pwdata;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end
endmodule // bcsc_stage_ctrl

/* File: dv/bcsc_props.sv */
// Checker of stage outputs and APB answer timing of the stage controller.
// Assumes it is bound to bcsc_stage_ctrl and sees only its ports.
`timescale 1ns/1ps
`include "bcsc_regs.vh"
module bcsc_props #(
  parameter TICK_CYC = 20
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Stage outputs
  input wire [2:0] stage_q,
  input wire charger_on_output,
  input wire warmer_on_output,
  input wire bal_done_q
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_apb_ans; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("apb answer late");
  property p_slv; pslverr |-> pready; endproperty
  a_slv: assert property (p_slv) else $error("pslverr without pready");
  property p_err; stage_q == `BCSC_ST_ERROR |->
    !charger_on_output && !warmer_on_output; endproperty
  a_err: assert property (p_err) else $error("outputs on in error");
  property p_fin; stage_q == `BCSC_ST_FINISH |-> !charger_on_output;
  endproperty
  a_fin: assert property (p_fin) else $error("charger on when done");
  property p_heat; stage_q == `BCSC_ST_PREHEAT |->
    warmer_on_output && !charger_on_output; endproperty
  a_heat: assert property (p_heat) else $error("preheat outputs");
  property p_idle; stage_q == `BCSC_ST_IDLE |->
    !charger_on_output && !warmer_on_output; endproperty
  a_idle: assert property (p_idle) else $error("outputs on when idle");
  property p_noback; stage_q == `BCSC_ST_BAL |=> stage_q != `BCSC_ST_MAIN;
  endproperty
  a_noback: assert property (p_noback) else $error("back to main");
  property p_done; bal_done_q |-> stage_q == `BCSC_ST_FINISH ##1
    !bal_done_q; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_one; stage_q <= `BCSC_ST_ERROR; endproperty
  a_one: assert property (p_one) else $error("stage code invalid");
endmodule // bcsc_props

bind bcsc_stage_ctrl bcsc_props #(.TICK_CYC(TICK_CYC)) props_u (.pclk,
  .presetn, .psel, .penable, .pready, .pslverr, .stage_q,
  .charger_on_output, .warmer_on_output, .bal_done_q);

/* File: dv/bcsc_charger_model.sv */
// Charger side model: mains sense level and periodic CAN message pulses.
// Assumes the bench commands plugging and message traffic.
`timescale 1ns/1ps
module bcsc_charger_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Commands
  input wire plug,
  input wire msg_en,
  // Charger lines
  output wire mains_present_input,
  output reg charger_msg_rx
);
  // ****************************************************************
  // Mains sense and messages
  // ****************************************************************
  reg [5:0] per_q;
  assign mains_present_input = plug;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q <= 6'h00;
      charger_msg_rx <= 1'b0;
    end else begin
      per_q <= (per_q == 6'h27) ? 6'h00 : per_q + 6'h01;
      charger_msg_rx <= msg_en && (per_q == 6'h00);
    end
  end
endmodule // bcsc_charger_model

/* File: dv/testbench.sv */
// Self-checking bench of the charge stage controller.
// Assumes a fast seconds tick set through TICK_CYC.
`timescale 1ns/1ps
`include "bcsc_regs.vh"
module testbench;
  localparam TK = 20;
  reg pclk, presetn, psel, penable, pwrite, plug, msg_en;
  reg [7:0] paddr, lowest_temp, module_temp_max, cell_temp_max;
  reg [31:0] pwdata, rd;
  reg [15:0] max_cell_mv, min_cell_mv, cells_found, charge_current;
  reg [6:0] max_bal_rate, min_bal_rate;
  reg [3:0] prot_active;
  reg cell_comm_ok, er;
  wire [31:0] prdata;
  wire [15:0] bal_thr_q;
  wire [2:0] stage_q;
  wire pready, pslverr, mains_present_input, charger_msg_rx;
  wire charger_on_output, warmer_on_output, bal_done_q;
  integer n_mismatch, cmp_count, cyc, el, i;
  bcsc_stage_ctrl #(.TICK_CYC(TK)) dut_u (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .max_cell_mv,
    .min_cell_mv, .lowest_temp, .module_temp_max, .cell_temp_max,
    .cells_found, .cell_comm_ok, .max_bal_rate, .min_bal_rate,
    .charge_current, .prot_active, .mains_present_input, .charger_msg_rx,
    .charger_on_output, .warmer_on_output, .stage_q, .bal_thr_q,
    .bal_done_q);
  bcsc_charger_model chg_u (.pclk, .presetn, .plug, .msg_en,
    .mains_present_input, .charger_msg_rx);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task report_and_stop;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin apb(1'b0, a, 32'h0); chk("rdata", e, rd); end
  endtask
  task wt(input [2:0] s, input integer lim);
    begin
      el = 0;
      while (stage_q !== s && el < lim) begin @(posedge pclk); el++; end
      chk("stage", s, stage_q);
    end
  endtask
  task fault(input integer k, input v);
    begin
      case (k)
        0: cells_found <= v ? 16'h000f : 16'h0010;
        1, 2, 3, 4: prot_active[k-1] <= v;
        5: module_temp_max <= v ? 8'h3d : 8'h19;
        6: cell_temp_max <= v ? 8'h3d : 8'h19;
        7: cell_comm_ok <= !v;
        default: max_cell_mv <= v ? 16'h1101 : 16'h0f3c;
      endcase
      @(posedge pclk);
    end
  endtask
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin n_mismatch++; report_and_stop; end
  end
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    n_mismatch = 0; cmp_count = 0; cyc = 0; presetn = 0; psel = 0;
    penable = 0; pwrite = 0; paddr = 0; pwdata = 0; plug = 0; msg_en = 0;
    max_cell_mv = 16'h0f3c; min_cell_mv = 16'h0f30; lowest_temp = 8'h19;
    module_temp_max = 8'h19; cell_temp_max = 8'h19; cells_found = 16'h0010;
    cell_comm_ok = 1; max_bal_rate = 0; min_bal_rate = 0; prot_active = 0;
    charge_current = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`BCSC_OFS_CTRL, 32'h000000f0);
    rdc(`BCSC_OFS_VFULL, 32'h0f001000);
    rdc(`BCSC_OFS_VLOW, 32'h0a000014);
    rdc(`BCSC_OFS_VLIM, 32'h11000f80);
    rdc(`BCSC_OFS_TEMP, 32'h003c3c01);
    rdc(`BCSC_OFS_COUNT, 32'h00100010);
    rdc(`BCSC_OFS_DUR0, 32'h1c201c20);
    rdc(`BCSC_OFS_DUR1, 32'h003c1c20);
    rdc(`BCSC_OFS_STAT, 32'h10000000);
    apb(1'b0, 8'h24, 32'h0); chk("unmapped err", 1, er);
    apb(1'b1, `BCSC_OFS_STAT, 32'h0); chk("stat write err", 1, er);
    apb(1'b1, `BCSC_OFS_DUR0, 32'h001e001e);
    apb(1'b1, `BCSC_OFS_DUR1, 32'h003c00c8);
    min_cell_mv <= 16'h0900; plug <= 1'b1;
    wt(`BCSC_ST_MAIN, 10);
    chk("charger on", 1, charger_on_output);
    min_cell_mv <= 16'h0f30;
    apb(1'b1, `BCSC_OFS_VFULL, 32'h0f000fff); chk("lock err", 1, er);
    rdc(`BCSC_OFS_VFULL, 32'h0f001000);
    apb(1'b1, `BCSC_OFS_CTRL, 32'h000000f5); chk("inv err", 0, er);
    rdc(`BCSC_OFS_CTRL, 32'h000000f4);
    chk("stage", `BCSC_ST_IDLE, stage_q);
    apb(1'b1, `BCSC_OFS_CTRL, 32'h000000f0);
    wt(`BCSC_ST_MAIN, 10);
    lowest_temp <= 8'hfb;
    wt(`BCSC_ST_PREHEAT, 10);
    lowest_temp <= 8'h19;
    wt(`BCSC_ST_MAIN, 10);
    max_cell_mv <= 16'h0f10; min_cell_mv <= 16'h0e00;
    repeat (3) @(posedge pclk);
    chk("early thr", 16'h0e05, bal_thr_q);
    max_cell_mv <= 16'h0f3c; min_cell_mv <= 16'h0f30;
    repeat (3) @(posedge pclk);
    chk("thr", 16'h1000, bal_thr_q);
    for (i = 0; i < 9; i++) begin
      fault(i, 1'b1);
      wt(`BCSC_ST_ERROR, 10);
      fault(i, 1'b0);
      wt(`BCSC_ST_MAIN, 10);
    end
    max_cell_mv <= 16'h1000; min_cell_mv <= 16'h0fe0; max_bal_rate <= 50;
    wt(`BCSC_ST_BAL, 10);
    chk("thr", 16'h1000, bal_thr_q);
    max_cell_mv <= 16'h1014;
    repeat (5) @(posedge pclk);
    chk("charger on", 1, charger_on_output);
    max_cell_mv <= 16'h1015;
    repeat (3) @(posedge pclk);
    chk("charger on", 0, charger_on_output);
    chk("dissip thr", 16'h0ff4, bal_thr_q);
    repeat (12 * TK) @(posedge pclk);
    chk("charger on", 0, charger_on_output);
    max_bal_rate <= 5; max_cell_mv <= 16'h1000;
    repeat (3) @(posedge pclk);
    chk("charger on", 1, charger_on_output);
    max_cell_mv <= 16'h1015; min_cell_mv <= 16'h1008;
    repeat (8 * TK) @(posedge pclk);
    chk("stage", `BCSC_ST_BAL, stage_q);
    wt(`BCSC_ST_FINISH, 4 * TK);
    max_cell_mv <= 16'h0fa0; min_cell_mv <= 16'h0f90; lowest_temp <= 8'hfb;
    wt(`BCSC_ST_PREHEAT, 10);
    lowest_temp <= 8'h19;
    wt(`BCSC_ST_FINISH, 10);
    max_cell_mv <= 16'h0f70; min_cell_mv <= 16'h0f60;
    wt(`BCSC_ST_MAIN, 10);
    plug <= 1'b0;
    wt(`BCSC_ST_IDLE, 10);
    plug <= 1'b1;
    wt(`BCSC_ST_ERROR, 40 * TK);
    chk("overrun late", 1, el >= 30 * TK);
    repeat (40) @(posedge pclk);
    chk("stage", `BCSC_ST_ERROR, stage_q);
    apb(1'b1, `BCSC_OFS_DUR1, 32'h000300c8); chk("err write", 0, er);
    rdc(`BCSC_OFS_DUR1, 32'h000300c8);
    plug <= 1'b0; cell_comm_ok <= 1'b0;
    apb(1'b1, `BCSC_OFS_CTRL, 32'h000000f8);
    plug <= 1'b1;
    wt(`BCSC_ST_MAIN, 10);
    repeat (TK) @(posedge pclk);
    chk("stage", `BCSC_ST_MAIN, stage_q);
    wt(`BCSC_ST_ERROR, 5 * TK);
    plug <= 1'b0; cell_comm_ok <= 1'b1;
    apb(1'b1, `BCSC_OFS_CTRL, 32'h000000f1);
    min_cell_mv <= 16'h0900; msg_en <= 1'b1;
    wt(`BCSC_ST_PRECHG, 100);
    apb(1'b1, `BCSC_OFS_CTRL, 32'h000000f5); chk("can err", 1, er);
    max_cell_mv <= 16'h1000; min_cell_mv <= 16'h0ff8; charge_current <= 32;
    max_bal_rate <= 50; min_bal_rate <= 30;
    wt(`BCSC_ST_BAL, 10);
    repeat (20) @(posedge pclk);
    chk("stage", `BCSC_ST_BAL, stage_q);
    charge_current <= 16'h000f;
    wt(`BCSC_ST_FINISH, 10);
    msg_en <= 1'b0;
    wt(`BCSC_ST_IDLE, 20 * TK);
    chk("msg gap", 1, el >= 12 * TK);
    report_and_stop;
  end
endmodule // testbench
